//--- card_bridge_compat_control_params.svh
// register offsets, field positions, reset values and timing counts of the compat control bank
`ifndef CARD_BRIDGE_COMPAT_CONTROL_PARAMS_SVH
`define CARD_BRIDGE_COMPAT_CONTROL_PARAMS_SVH

// register indices; the bus byte address is four times the index
`define RETRY_REG_IDX 10'h090
`define ROUTE_REG_IDX 10'h091
`define MODE_REG_IDX 10'h092
`define IRQ_STAT_IDX 10'h096
`define IRQ_MASK_IDX 10'h097

// reset values
`define RETRY_RESET 8'hC0
`define ROUTE_RESET 8'h00
`define MODE_RESET 8'h66
`define IRQ_MASK_RESET 3'h0

// retry timeout control and status fields
`define HOST_RETRY_EN_BIT 7
`define CB_RETRY_EN_BIT 6
`define CB_EXPIRED_BIT 3
`define HOST_EXPIRED_BIT 1

// socket routing control fields
`define RING_EN_BIT 7
`define ZV_TRI_BIT 6
`define SPARE_BIT 5
`define AUDIO_MUX_BIT 2
`define SPEAKER_EN_BIT 1
`define CARD_IRQ_BIT 0

// interrupt mode and power control fields
`define PWR_LOCK_BIT 7
`define LV_FORCE_BIT 6
`define DIAG_FIVE_BIT 5
`define TEST_HIGH_BIT 3
`define MODE_MSB 2
`define MODE_LSB 1
`define TEST_LOW_BIT 0

// interrupt status and mask fields
`define EV_HOST_BIT 0
`define EV_CB_BIT 1
`define EV_CARD_BIT 2

// retry timeout, in clock cycles
`define RETRY_TIMEOUT_CYCLES 32768
`define RETRY_CNT_W 16

`endif

//--- card_bridge_compat_control_pkg.sv
// types shared by the compat control bank and its bench
`include "card_bridge_compat_control_params.svh"
package card_bridge_compat_control_pkg;

	// interrupt signalling modes, in field encoding order
	typedef enum logic [1:0] {
		IRQ_PAR_PCI_ONLY,
		IRQ_PAR_LEGACY_PAR_PCI,
		IRQ_SER_LEGACY_PAR_PCI,
		IRQ_SER_ALL
	} irq_mode_t;

	// event inputs from the bridge core and the socket
	typedef struct packed {
		logic hostRetryIssued;   // pulse: host master was retried
		logic hostRetryDone;     // pulse: retried host master came back
		logic cardBusRetryIssued;
		logic cardBusRetryDone;
		logic cardFunctionIrq;   // pulse: card functional interrupt
	} card_events_t;

	// one retry timeout channel
	typedef struct packed {
		logic                      pending;
		logic                      expire;
		logic [`RETRY_CNT_W-1:0]   count;
	} retry_chan_t;

	// whole state of the bank
	typedef struct packed {
		logic        hostRetryEn;
		logic        cardBusRetryEn;
		logic        cardBusExpired;
		logic        hostExpired;
		logic        ringEn;
		logic        zvTristate;
		logic        spareBit;
		logic        audioMuxEn;
		logic        speakerEn;
		logic        cardIrqFlag;
		logic        powerLock;
		logic        lowVoltForce;
		logic        diagFive;
		logic        testHigh;
		irq_mode_t   irqMode;
		logic        testLow;
		logic [2:0]  irqStatus;
		logic [2:0]  irqMask;
		retry_chan_t hostChan;
		retry_chan_t cardBusChan;
		logic [7:0]  rdata;
		logic        slvErr;
		logic        ringPme;
		logic        ringMfunc;
		logic        audioPwm;
		logic        speakerOut;
		logic        speakerOe;
		logic        zvOe;
		logic        powerDownGo;
	} state_t;

endpackage : card_bridge_compat_control_pkg

//--- card_bridge_compat_control_regs.sv
// compat retry, socket routing and interrupt mode control bank with an APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "card_bridge_compat_control_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - unanswered retry for timeout sets expired flag
// - bit 7 enables host retry counter, reset one
// - bit 6 enables card bus counter, reset one
// - card bus expired flag, write one clears
// - host expired flag, write one clears
// - reserved bits read zero, ignore writes
// - ring enable gates ring output routing
// - zoomed video bit tristates video terminals
// - routing bit five is plain storage
// - audio mux bit routes card audio
// - speaker enable routes speaker, else undriven
// - card interrupt sets flag, write one clears
// - power lock blocks power down in D3
// - bit six forces low voltage capability
// - diagnostic bit five resets to one
// - bits two to one select interrupt mode
module card_bridge_compat_control_regs #(
	parameter int ADDR_W      = 12,                       // apb address width
	parameter int RETRY_LIMIT = `RETRY_TIMEOUT_CYCLES     // retry timeout in cycles
) (
	input  wire logic                                 clk,
	input  wire logic                                 rst_n,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [ADDR_W-1:0]                    paddr,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire card_bridge_compat_control_pkg::card_events_t events,
	input  wire logic                                 ringIndicate,
	input  wire logic                                 ringMuxSelect,
	input  wire logic                                 cardAudioSignal,
	input  wire logic                                 cardSpeakerSignal,
	input  wire logic                                 socketPowerDownReq,
	input  wire logic                                 controllerInD3,
	output logic                                      ringIndicateOutput,
	output logic                                      ringToMultifunction,
	output logic                                      audioPwmOutput,
	output logic                                      speakerOutputPin,
	output logic                                      speakerOutputOe,
	output logic                                      zoomedVideoOe,
	output logic                                      socketPowerDownGo,
	output logic                                      lowVoltageCapable,
	output card_bridge_compat_control_pkg::irq_mode_t irqSignallingMode,
	output logic                                      irq
);

	////////////////////////////////////////////////////////////////////////////////
	// helper functions

	// retry channel step; restarts on every new retry
	function automatic card_bridge_compat_control_pkg::retry_chan_t stepChan(
		input card_bridge_compat_control_pkg::retry_chan_t c,
		input logic en,
		input logic issued,
		input logic done,
		input logic [`RETRY_CNT_W-1:0] lastCount
	);
		card_bridge_compat_control_pkg::retry_chan_t n;
		n = c;
		n.expire = 1'b0;
		if (!en) begin
			// disabled counter forgets the pending retry
			n.pending = 1'b0;
			n.count = '0;
		end else if (issued) begin
			// each new retry starts a fresh count
			n.pending = 1'b1;
			n.count = '0;
		end else if (done) begin
			// master came back in time
			n.pending = 1'b0;
		end else if (c.pending) begin
			if (c.count == lastCount) begin
				// timeout reached without return
				n.expire = 1'b1;
				n.pending = 1'b0;
			end else begin
				n.count = c.count + 1'b1;
			end
		end
		return n;
	endfunction : stepChan

	// write of the retry register; flags clear on a one
	function automatic card_bridge_compat_control_pkg::state_t writeRetry(
		input card_bridge_compat_control_pkg::state_t s,
		input logic [7:0] b
	);
		card_bridge_compat_control_pkg::state_t n;
		n = s;
		n.hostRetryEn = b[`HOST_RETRY_EN_BIT];
		n.cardBusRetryEn = b[`CB_RETRY_EN_BIT];
		if (b[`CB_EXPIRED_BIT]) begin
			n.cardBusExpired = 1'b0;
		end
		if (b[`HOST_EXPIRED_BIT]) begin
			n.hostExpired = 1'b0;
		end
		return n;
	endfunction : writeRetry

	// write of the socket routing register
	function automatic card_bridge_compat_control_pkg::state_t writeRoute(
		input card_bridge_compat_control_pkg::state_t s,
		input logic [7:0] b
	);
		card_bridge_compat_control_pkg::state_t n;
		n = s;
		n.ringEn = b[`RING_EN_BIT];
		n.zvTristate = b[`ZV_TRI_BIT];
		n.spareBit = b[`SPARE_BIT];
		n.audioMuxEn = b[`AUDIO_MUX_BIT];
		n.speakerEn = b[`SPEAKER_EN_BIT];
		if (b[`CARD_IRQ_BIT]) begin
			n.cardIrqFlag = 1'b0;
		end
		return n;
	endfunction : writeRoute

	// write of the interrupt mode and power register
	function automatic card_bridge_compat_control_pkg::state_t writeMode(
		input card_bridge_compat_control_pkg::state_t s,
		input logic [7:0] b
	);
		card_bridge_compat_control_pkg::state_t n;
		n = s;
		n.powerLock = b[`PWR_LOCK_BIT];
		n.lowVoltForce = b[`LV_FORCE_BIT];
		n.diagFive = b[`DIAG_FIVE_BIT];
		n.testHigh = b[`TEST_HIGH_BIT];
		n.irqMode = card_bridge_compat_control_pkg::irq_mode_t'(b[`MODE_MSB:`MODE_LSB]);
		n.testLow = b[`TEST_LOW_BIT];
		return n;
	endfunction : writeMode

	// reset state built from the register reset bytes
	function automatic card_bridge_compat_control_pkg::state_t resetState();
		card_bridge_compat_control_pkg::state_t n;
		n = '0;
		n = writeRetry(n, `RETRY_RESET);
		n = writeRoute(n, `ROUTE_RESET);
		n = writeMode(n, `MODE_RESET);
		n.irqMask = `IRQ_MASK_RESET;
		n.zvOe = 1'b1;
		return n;
	endfunction : resetState

	// read decode; reserved bits stay zero
	function automatic logic [8:0] readReg(
		input card_bridge_compat_control_pkg::state_t s,
		input logic [ADDR_W-3:0] idx
	);
		logic [7:0] b;
		logic       hit;
		b = 8'h00;
		hit = 1'b1;
		case (idx)
			`RETRY_REG_IDX: begin
				b[`HOST_RETRY_EN_BIT] = s.hostRetryEn;
				b[`CB_RETRY_EN_BIT] = s.cardBusRetryEn;
				b[`CB_EXPIRED_BIT] = s.cardBusExpired;
				b[`HOST_EXPIRED_BIT] = s.hostExpired;
			end
			`ROUTE_REG_IDX: begin
				b[`RING_EN_BIT] = s.ringEn;
				b[`ZV_TRI_BIT] = s.zvTristate;
				b[`SPARE_BIT] = s.spareBit;
				b[`AUDIO_MUX_BIT] = s.audioMuxEn;
				b[`SPEAKER_EN_BIT] = s.speakerEn;
				b[`CARD_IRQ_BIT] = s.cardIrqFlag;
			end
			`MODE_REG_IDX: begin
				b[`PWR_LOCK_BIT] = s.powerLock;
				b[`LV_FORCE_BIT] = s.lowVoltForce;
				b[`DIAG_FIVE_BIT] = s.diagFive;
				b[`TEST_HIGH_BIT] = s.testHigh;
				b[`MODE_MSB:`MODE_LSB] = s.irqMode;
				b[`TEST_LOW_BIT] = s.testLow;
			end
			`IRQ_STAT_IDX: begin
				b[2:0] = s.irqStatus;
			end
			`IRQ_MASK_IDX: begin
				b[2:0] = s.irqMask;
			end
			default: begin
				// unmapped word answers with an error
				hit = 1'b0;
			end
		endcase
		return {hit, b};
	endfunction : readReg

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	localparam card_bridge_compat_control_pkg::state_t STATE_RESET = resetState();
	localparam logic [`RETRY_CNT_W-1:0] LAST_COUNT = `RETRY_CNT_W'(RETRY_LIMIT - 1);

	logic [1:0] rstSync_q;   // release synchroniser
	logic       rstSyncN;    // synchronised active low reset

	// assert at once, release after two edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end

	assign rstSyncN = rstSync_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// next state

	card_bridge_compat_control_pkg::state_t state_q;   // all registered state
	card_bridge_compat_control_pkg::state_t state_d;   // its next value

	logic       setupPhase;  // apb setup cycle
	logic       accessWr;    // apb write taking effect
	logic       misaligned;  // byte address not word aligned
	logic [8:0] rdHit;       // read decode result

	assign setupPhase = psel && !penable;
	assign accessWr = psel && penable && pwrite;
	assign misaligned = |paddr[1:0];

	always_comb begin
		state_d = state_q;
		rdHit = readReg(state_q, paddr[ADDR_W-1:2]);

		// retry timeout channels
		state_d.hostChan = stepChan(state_q.hostChan, state_q.hostRetryEn,
			events.hostRetryIssued, events.hostRetryDone, LAST_COUNT);
		state_d.cardBusChan = stepChan(state_q.cardBusChan, state_q.cardBusRetryEn,
			events.cardBusRetryIssued, events.cardBusRetryDone, LAST_COUNT);

		// register writes land at the access edge; misaligned writes are dropped
		if (accessWr && !misaligned) begin
			case (paddr[ADDR_W-1:2])
				`RETRY_REG_IDX: begin
					state_d = writeRetry(state_d, pwdata[7:0]);
				end
				`ROUTE_REG_IDX: begin
					state_d = writeRoute(state_d, pwdata[7:0]);
				end
				`MODE_REG_IDX: begin
					state_d = writeMode(state_d, pwdata[7:0]);
				end
				`IRQ_STAT_IDX: begin
					state_d.irqStatus = state_q.irqStatus & ~pwdata[2:0];
				end
				`IRQ_MASK_IDX: begin
					state_d.irqMask = pwdata[2:0];
				end
				default: begin
					// unmapped: nothing stored
					state_d.irqMask = state_d.irqMask;
				end
			endcase
		end

		// hardware sets come after clears so an event is never lost
		if (state_d.hostChan.expire) begin
			state_d.hostExpired = 1'b1;
			state_d.irqStatus[`EV_HOST_BIT] = 1'b1;
		end
		if (state_d.cardBusChan.expire) begin
			state_d.cardBusExpired = 1'b1;
			state_d.irqStatus[`EV_CB_BIT] = 1'b1;
		end
		if (events.cardFunctionIrq) begin
			state_d.cardIrqFlag = 1'b1;
			state_d.irqStatus[`EV_CARD_BIT] = 1'b1;
		end

		// read data and error captured in the setup cycle
		if (setupPhase) begin
			state_d.rdata = rdHit[7:0];
			state_d.slvErr = !rdHit[8] || misaligned;
		end

		// ring routing; pme pin only when the system mux picks the ring
		state_d.ringPme = state_q.ringEn && ringIndicate && !ringMuxSelect;
		state_d.ringMfunc = state_q.ringEn && ringIndicate;

		// audio to the multifunction pwm terminal
		state_d.audioPwm = state_q.audioMuxEn && cardAudioSignal;

		// speaker pin is driven only while routed
		state_d.speakerOut = state_q.speakerEn && cardSpeakerSignal;
		state_d.speakerOe = state_q.speakerEn;

		// zoomed video terminals float while the bit is set
		state_d.zvOe = !state_q.zvTristate;

		// power down refused while locked and in D3
		state_d.powerDownGo = socketPowerDownReq &&
			!(state_q.powerLock && controllerInD3);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// one register stage for the whole bank
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_q <= STATE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// zero wait state slave; error only shown in the access phase
	assign pready = 1'b1;
	assign pslverr = psel && penable && state_q.slvErr;
	assign prdata = {24'h000000, state_q.rdata};

	// routed socket signals, all from flip-flops
	assign ringIndicateOutput = state_q.ringPme;
	assign ringToMultifunction = state_q.ringMfunc;
	assign audioPwmOutput = state_q.audioPwm;
	assign speakerOutputPin = state_q.speakerOut;
	assign speakerOutputOe = state_q.speakerOe;
	assign zoomedVideoOe = state_q.zvOe;
	assign socketPowerDownGo = state_q.powerDownGo;

	// configuration seen by the rest of the bridge
	assign lowVoltageCapable = state_q.lowVoltForce;
	assign irqSignallingMode = state_q.irqMode;

	// level interrupt from unmasked sticky events
	assign irq = |(state_q.irqStatus & state_q.irqMask);

endmodule : card_bridge_compat_control_regs

//--- card_bridge_compat_control_asserts.sv
// port checker for the compat control bank
`timescale 1ns/1ps
`include "card_bridge_compat_control_params.svh"
module card_bridge_compat_control_asserts #(
	parameter int ADDR_W      = 12,                    // apb address width
	parameter int RETRY_LIMIT = `RETRY_TIMEOUT_CYCLES  // retry timeout in cycles, kept for the bind
) (
	input wire logic                                 clk,
	input wire logic                                 rst_n,
	input wire logic                                 psel,
	input wire logic                                 penable,
	input wire logic                                 pwrite,
	input wire logic                                 pready,
	input wire logic [ADDR_W-1:0]                    paddr,
	input wire logic [31:0]                          pwdata,
	input wire logic [31:0]                          prdata,
	input wire logic                                 pslverr,
	input wire logic                                 ringIndicate,
	input wire logic                                 ringMuxSelect,
	input wire logic                                 cardAudioSignal,
	input wire logic                                 cardSpeakerSignal,
	input wire logic                                 socketPowerDownReq,
	input wire logic                                 controllerInD3,
	input wire logic                                 ringIndicateOutput,
	input wire logic                                 ringToMultifunction,
	input wire logic                                 audioPwmOutput,
	input wire logic                                 speakerOutputPin,
	input wire logic                                 speakerOutputOe,
	input wire logic                                 socketPowerDownGo,
	input wire logic                                 lowVoltageCapable,
	input wire card_bridge_compat_control_pkg::irq_mode_t irqSignallingMode
);
	////////////////////////////////////////
	// helpers: a completed access and the mode register write
	wire logic       acc    = psel && penable && pready;
	wire logic       modeWr = acc && pwrite && paddr == ADDR_W'({`MODE_REG_IDX, 2'b00});
	wire logic [1:0] wrMode = pwdata[2:1];
	wire logic       wrLv   = pwdata[6];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////
	// routed outputs follow their inputs one cycle late
	a_ring_gated: assert property (ringIndicateOutput |-> $past(ringIndicate) && !$past(ringMuxSelect))
		else $error("ring output without ring input or with mux set");
	a_ring_mfunc: assert property (ringToMultifunction |-> $past(ringIndicate))
		else $error("ring multifunction output without ring input");
	a_audio_route: assert property (audioPwmOutput |-> $past(cardAudioSignal))
		else $error("audio output without card audio");
	a_speaker_drive: assert property (speakerOutputPin |-> speakerOutputOe && $past(cardSpeakerSignal))
		else $error("speaker pin high while undriven or without card speaker");
	// power down goes through only when asked, and always outside D3
	a_power_cause: assert property (socketPowerDownGo |-> $past(socketPowerDownReq))
		else $error("power down without request");
	a_power_free: assert property (socketPowerDownReq && !controllerInD3 |=> socketPowerDownGo)
		else $error("power down outside D3 was blocked");
	// mode field tracks software writes only; capability force follows each write
	a_mode_write: assert property (modeWr |=> irqSignallingMode == $past(wrMode))
		else $error("interrupt mode does not match write");
	a_mode_hold: assert property (!$stable(irqSignallingMode) |-> $past(modeWr))
		else $error("interrupt mode changed without a write");
	a_lv_write: assert property (modeWr |=> lowVoltageCapable == $past(wrLv))
		else $error("capability force does not match write");
	// bus answers: one byte per word, misaligned refused
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_err_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");

	c_mode_write: cover property (modeWr);
	c_speaker: cover property (speakerOutputPin);
	c_power_go: cover property (socketPowerDownGo);
endmodule : card_bridge_compat_control_asserts

bind card_bridge_compat_control_regs card_bridge_compat_control_asserts #(
	.ADDR_W(ADDR_W), .RETRY_LIMIT(RETRY_LIMIT)
) u_asserts (.clk, .rst_n, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .prdata, .pslverr,
	.ringIndicate, .ringMuxSelect, .cardAudioSignal, .cardSpeakerSignal, .socketPowerDownReq,
	.controllerInD3, .ringIndicateOutput, .ringToMultifunction, .audioPwmOutput, .speakerOutputPin,
	.speakerOutputOe, .socketPowerDownGo, .lowVoltageCapable, .irqSignallingMode);

//--- card_side_model.sv
// far-side model: retried host and card bus masters and a card raising interrupts
`timescale 1ns/1ps
module card_side_model (
	input  wire logic                                    clk,
	output card_bridge_compat_control_pkg::card_events_t ev
);
	initial ev = '0;

	////////////////////////////////////////
	// retried master: returns after back cycles, never when back is 0
	task automatic retry(input logic cb, input int back);
		if (cb) ev.cardBusRetryIssued <= 1'b1;
		else ev.hostRetryIssued <= 1'b1;
		@(posedge clk);
		ev <= '0;
		if (back > 0) begin
			repeat (back - 1) @(posedge clk);
			if (cb) ev.cardBusRetryDone <= 1'b1;
			else ev.hostRetryDone <= 1'b1;
			@(posedge clk);
			ev <= '0;
		end
	endtask : retry

	// one-cycle functional interrupt from the card
	task automatic card_irq();
		ev.cardFunctionIrq <= 1'b1;
		@(posedge clk);
		ev <= '0;
	endtask : card_irq
endmodule : card_side_model

//--- card_bridge_compat_control_regs_bench.sv
// self-checking bench for the compat control bank
`timescale 1ns/1ps
module card_bridge_compat_control_regs_bench;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  rdv;
	logic        ringIndicate, ringMuxSelect, cardAudioSignal, cardSpeakerSignal;
	logic        socketPowerDownReq, controllerInD3, socketPowerDownGo, lowVoltageCapable;
	logic        ringIndicateOutput, ringToMultifunction, audioPwmOutput;
	logic        speakerOutputPin, speakerOutputOe, zoomedVideoOe;
	card_bridge_compat_control_pkg::irq_mode_t    irqSignallingMode;
	card_bridge_compat_control_pkg::card_events_t ev;
	int          fails, numChecks;

	// short retry timeout keeps the run brief
	card_bridge_compat_control_regs #(.ADDR_W(12), .RETRY_LIMIT(8)) dut (.clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .events(ev), .ringIndicate, .ringMuxSelect,
		.cardAudioSignal, .cardSpeakerSignal, .socketPowerDownReq, .controllerInD3, .ringIndicateOutput,
		.ringToMultifunction, .audioPwmOutput, .speakerOutputPin, .speakerOutputOe, .zoomedVideoOe,
		.socketPowerDownGo, .lowVoltageCapable, .irqSignallingMode, .irq);
	card_side_model partner (.clk(clk), .ev(ev));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// one apb transfer; an idle edge first so psel is never set twice in a step
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdv = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		check({err, rdv}, {1'b0, exp});
	endtask : rdc

	// routed outputs settle one edge after a change; the task waits two
	task automatic outs(input logic [5:0] exp);
		repeat (2) @(posedge clk);
		#1;
		check({ringIndicateOutput, ringToMultifunction, audioPwmOutput, speakerOutputPin,
			speakerOutputOe, zoomedVideoOe}, exp);
	endtask : outs

	task automatic pwr(input logic d3, input logic exp);
		@(posedge clk);
		controllerInD3 <= d3;
		socketPowerDownReq <= 1'b1;
		@(posedge clk);
		socketPowerDownReq <= 1'b0;
		#1;
		check(socketPowerDownGo, exp);
	endtask : pwr

	task automatic summarize();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	////////////////////////////////////////
	// watchdog: far beyond the expected run
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		summarize();
	end

	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, ringIndicate, ringMuxSelect} = '0;
		{cardAudioSignal, cardSpeakerSignal, socketPowerDownReq, controllerInD3, fails, numChecks} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(12'h240, 8'hC0);
		rdc(12'h244, 8'h00);
		rdc(12'h248, 8'h66);
		rdc(12'h258, 8'h00);
		rdc(12'h25C, 8'h00);
		$display("test reset values done");
		wr(12'h240, 8'hFF);
		rdc(12'h240, 8'hC0);
		wr(12'h240, 8'h40);
		partner.retry(1'b0, 0);
		repeat (12) @(posedge clk);
		rdc(12'h240, 8'h40);
		wr(12'h240, 8'h80);
		partner.retry(1'b1, 0);
		repeat (12) @(posedge clk);
		rdc(12'h240, 8'h80);
		wr(12'h240, 8'hC0);
		partner.retry(1'b0, 3);
		repeat (12) @(posedge clk);
		rdc(12'h240, 8'hC0);
		partner.retry(1'b0, 0);
		repeat (5) @(posedge clk);
		partner.retry(1'b0, 0);
		repeat (2) @(posedge clk);
		rdc(12'h240, 8'hC0);
		repeat (12) @(posedge clk);
		rdc(12'h240, 8'hC2);
		wr(12'h240, 8'hC0);
		rdc(12'h240, 8'hC2);
		wr(12'h240, 8'hC2);
		rdc(12'h240, 8'hC0);
		partner.retry(1'b1, 0);
		repeat (12) @(posedge clk);
		rdc(12'h240, 8'hC8);
		wr(12'h240, 8'hC0);
		rdc(12'h240, 8'hC8);
		wr(12'h240, 8'hC8);
		rdc(12'h240, 8'hC0);
		rdc(12'h258, 8'h03);
		check(irq, 1'b0);
		wr(12'h258, 8'h03);
		rdc(12'h258, 8'h00);
		$display("test retry timeouts done");
		ringIndicate <= 1'b1;
		cardAudioSignal <= 1'b1;
		cardSpeakerSignal <= 1'b1;
		outs(6'b000001);
		wr(12'h244, 8'hFF);
		rdc(12'h244, 8'hE6);
		outs(6'b111110);
		ringMuxSelect <= 1'b1;
		cardAudioSignal <= 1'b0;
		cardSpeakerSignal <= 1'b0;
		outs(6'b010010);
		wr(12'h244, 8'h20);
		rdc(12'h244, 8'h20);
		outs(6'b000001);
		$display("test socket routing done");
		for (int m = 0; m < 4; m++) begin
			wr(12'h248, {5'b01110, m[1:0], 1'b0});
			rdc(12'h248, {5'b01100, m[1:0], 1'b0});
			check({30'h0, irqSignallingMode}, m);
		end
		wr(12'h248, 8'h00);
		rdc(12'h248, 8'h00);
		check(lowVoltageCapable, 1'b0);
		wr(12'h248, 8'hE6);
		rdc(12'h248, 8'hE6);
		pwr(1'b1, 1'b0);
		pwr(1'b0, 1'b1);
		wr(12'h248, 8'h66);
		pwr(1'b1, 1'b1);
		$display("test mode and power done");
		wr(12'h25C, 8'h04);
		partner.card_irq();
		rdc(12'h244, 8'h21);
		rdc(12'h258, 8'h04);
		check(irq, 1'b1);
		wr(12'h244, 8'h01);
		rdc(12'h244, 8'h00);
		wr(12'h258, 8'h04);
		rdc(12'h258, 8'h00);
		check(irq, 1'b0);
		wr(12'h25C, 8'h00);
		partner.card_irq();
		rdc(12'h258, 8'h04);
		check(irq, 1'b0);
		wr(12'h258, 8'h04);
		wr(12'h244, 8'h01);
		$display("test interrupts done");
		apb(1'b0, 12'h24C, 8'h00);
		check({err, rdv}, 9'h100);
		apb(1'b1, 12'h245, 8'hFF);
		check(err, 1'b1);
		rdc(12'h244, 8'h00);
		$display("test refused access done");
		summarize();
	end
endmodule : card_bridge_compat_control_regs_bench
